// [core/pcdr_top.sv]
// Port configuration and data register set for four I/O ports
// Function
// - Ports A,B mode bit 0 plain I/O, 1 latched address; reset plain
// - Only ports A and B have mode registers; C,D never address output
// - Direction bit 1 output, 0 input; all pins input after reset
// - Ports A,B,C drive when direction bit or logic enable term is one
// - Port D direction register uses only its three low bits
// - Drive bit 1 on open-drain pin selects open drain; reset push-pull
// - Drive bit 1 on slew pin selects fast slew; reset slow
// - A,B: 7..4 open drain, 3..0 slew; C all drain; D 2..0 slew
// - Data-in read returns live pin levels
// - Data-out stores writes, drives enabled pins, reads back stored value
// - Output cell read returns cells; write loads unmasked cells, ports A-C
// - Mask bit 1 blocks bus loading of its cell; read/write, resets 0
// - Input cell location read-only, returns input cell outputs, ports A-C
// - Enable-out location read-only, returns driver enable state, A-C
// - Bit n maps pin n; all configuration registers clear at power-up
// - Registers reached by plain bus reads and writes at fixed offsets
// - Enable-out bit 1 when direction bit or logic enable term is one, even on a released open-drain pin
`timescale 1ns/1ps
module pcdr_top (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic io_sel,
    input wire logic [7:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [31:0] pin_in,
    input wire logic [23:0] pld_oe,
    input wire logic [15:0] latched_addr,
    input wire logic [23:0] in_cell,
    input wire logic [23:0] cell_next,
    output logic [7:0] bus_rdata,
    output logic [31:0] pin_out,
    output logic [31:0] pin_oe,
    output logic [31:0] pin_fast,
    output logic [23:0] cell_state
);
    logic [7:0] mode_q [pcdr_pkg::NPORT];
    logic [7:0] dir_q [pcdr_pkg::NPORT];
    logic [7:0] drive_q [pcdr_pkg::NPORT];
    logic [7:0] dout_q [pcdr_pkg::NPORT];
    logic [7:0] en_q [pcdr_pkg::NPORT];
    logic [7:0] mask_q [pcdr_pkg::NCELLPORT];
    logic [5:0] acc_type;
    logic [1:0] acc_port;
    logic acc_ok;
    logic wr_hit;
    logic rd_hit;
    logic [7:0] next_rdata;
    logic [7:0] rd_val;

    // Address split: register type above, port index in the low bits
    assign acc_type = bus_addr[pcdr_pkg::TYPE_LSB +: pcdr_pkg::TYPE_W];
    assign acc_port = bus_addr[pcdr_pkg::PORT_LSB +: pcdr_pkg::PORT_W];
    assign acc_ok = pcdr_pkg::pcdr_exists(acc_type, acc_port);
    assign wr_hit = io_sel && bus_wr && acc_ok;
    assign rd_hit = io_sel && bus_rd;

    // Per-port configuration and pin drivers
    generate
        for (genvar p = 0; p < pcdr_pkg::NPORT; p++) begin : g_port
            localparam logic [1:0] PI = 2'(p);
            localparam bit IS_D = (p == 3);
            localparam bit IS_AB = (p < 2);
            localparam logic [7:0] PMASK = IS_D ? pcdr_pkg::PIN_MASK_D
                                                : pcdr_pkg::PIN_MASK_FULL;
            localparam logic [7:0] ODM = IS_AB ? pcdr_pkg::OD_MASK_AB :
                                   (p == 2) ? pcdr_pkg::OD_MASK_C
                                            : pcdr_pkg::OD_MASK_D;
            localparam logic [7:0] SLM = IS_AB ? pcdr_pkg::SLEW_MASK_AB :
                                   (p == 2) ? pcdr_pkg::SLEW_MASK_C
                                            : pcdr_pkg::SLEW_MASK_D;
            logic sel;
            logic [7:0] oe_in;
            logic [7:0] adr_in;
            assign sel = wr_hit && (acc_port == PI);
            // Port D has no logic enable term and no address output
            if (IS_D) begin : g_nooe
                assign oe_in = 8'h00;
            end else begin : g_oe
                assign oe_in = pld_oe[p*8 +: 8];
            end
            if (IS_AB) begin : g_adr
                assign adr_in = latched_addr[p*8 +: 8];
            end else begin : g_noadr
                assign adr_in = 8'h00;
            end
            pcdr_port #(
                .PIN_MASK(PMASK),
                .OD_MASK(ODM),
                .SLEW_MASK(SLM),
                .HAS_MODE(IS_AB),
                .HAS_OEPT(!IS_D)
            ) u_port (
                .mclk(mclk),
                .nrst(nrst),
                .wr_mode(sel && acc_type == pcdr_pkg::OFF_MODE[7:2]),
                .wr_dir(sel && acc_type == pcdr_pkg::OFF_DIR[7:2]),
                .wr_drive(sel && acc_type == pcdr_pkg::OFF_DRIVE[7:2]),
                .wr_dout(sel && acc_type == pcdr_pkg::OFF_DATA_OUT[7:2]),
                .wdata(bus_wdata),
                .pld_oe(oe_in),
                .addr_val(adr_in),
                .mode(mode_q[p]),
                .dir(dir_q[p]),
                .drive(drive_q[p]),
                .dout(dout_q[p]),
                .pin_out(pin_out[p*8 +: 8]),
                .pin_oe(pin_oe[p*8 +: 8]),
                .pin_fast(pin_fast[p*8 +: 8]),
                .en_state(en_q[p])
            );
        end
    endgenerate

    // Output logic cells exist on ports A to C only
    generate
        for (genvar c = 0; c < pcdr_pkg::NCELLPORT; c++) begin : g_cell
            localparam logic [1:0] CI = 2'(c);
            logic csel;
            assign csel = wr_hit && (acc_port == CI);
            pcdr_cells #(
                .N(pcdr_pkg::PW)
            ) u_cells (
                .mclk(mclk),
                .nrst(nrst),
                .wr_cell(csel && acc_type == pcdr_pkg::OFF_OCELL[7:2]),
                .wr_mask(csel && acc_type == pcdr_pkg::OFF_MASK[7:2]),
                .wdata(bus_wdata),
                .cell_next(cell_next[c*8 +: 8]),
                .state(cell_state[c*8 +: 8]),
                .mask(mask_q[c])
            );
        end
    endgenerate

    // Read mux; absent registers and holes answer zero
    always_comb begin
        rd_val = 8'h00;
        if (acc_ok) begin
            case (acc_type)
                pcdr_pkg::OFF_DATA_IN[7:2]: begin
                    rd_val = pin_in[acc_port*8 +: 8];
                    if (acc_port == pcdr_pkg::PORT_D) begin
                        rd_val = rd_val & pcdr_pkg::PIN_MASK_D;
                    end
                end
                pcdr_pkg::OFF_DATA_OUT[7:2]: rd_val = dout_q[acc_port];
                pcdr_pkg::OFF_MODE[7:2]: rd_val = mode_q[acc_port];
                pcdr_pkg::OFF_DIR[7:2]: rd_val = dir_q[acc_port];
                pcdr_pkg::OFF_DRIVE[7:2]: rd_val = drive_q[acc_port];
                pcdr_pkg::OFF_OCELL[7:2]: begin
                    rd_val = cell_state[acc_port*8 +: 8];
                end
                pcdr_pkg::OFF_MASK[7:2]: rd_val = mask_q[acc_port];
                pcdr_pkg::OFF_ICELL[7:2]: begin
                    rd_val = in_cell[acc_port*8 +: 8];
                end
                pcdr_pkg::OFF_ENOUT[7:2]: rd_val = en_q[acc_port];
                default: rd_val = 8'h00;
            endcase
        end
        // Data holds between reads so a slow host can sample late
        next_rdata = rd_hit ? rd_val : bus_rdata;
    end

    // Read data register
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            bus_rdata <= pcdr_pkg::RST_VAL;
        end else begin
            bus_rdata <= next_rdata;
        end
    end

    // Checks on the register set and the pin drivers
    chk_cd_nomode: assert property (@(posedge mclk) disable iff (!nrst)
        (mode_q[2] == 8'h00) && (mode_q[3] == 8'h00))
        else $error("mode register set on port without address output");

    chk_dir_write: assert property (@(posedge mclk) disable iff (!nrst)
        (io_sel && bus_wr && bus_addr == pcdr_pkg::OFF_DIR)
        |=> (dir_q[0] == $past(bus_wdata)))
        else $error("direction write not stored");

    chk_oe_merge: assert property (@(posedge mclk) disable iff (!nrst)
        ##1 (pin_oe[3] == $past(dir_q[0][3] | pld_oe[3])))
        else $error("port A driver enable not direction or term");

    chk_portd_dir: assert property (@(posedge mclk) disable iff (!nrst)
        (dir_q[3][7:3] == 5'h00) && (pin_oe[31:27] == 5'h00))
        else $error("port D upper direction bits active");

    chk_od_release: assert property (@(posedge mclk) disable iff (!nrst)
        (drive_q[2][0] && dout_q[2][0]) ##1 drive_q[2][0]
        |-> (pin_oe[16] == 1'b0) && (pin_out[16] == 1'b0))
        else $error("open drain pin driven while value high");

    chk_slew_map: assert property (@(posedge mclk) disable iff (!nrst)
        (pin_fast[7:4] == 4'h0) && (pin_fast[23:16] == 8'h00)
        && (pin_fast[31:27] == 5'h00))
        else $error("slew selected on pin without slew control");

    chk_slew_fast: assert property (@(posedge mclk) disable iff (!nrst)
        $rose(drive_q[1][2]) |=> pin_fast[10])
        else $error("fast slew not applied after drive write");

    chk_datain_rd: assert property (@(posedge mclk) disable iff (!nrst)
        (io_sel && bus_rd && bus_addr == (pcdr_pkg::OFF_DATA_IN + 8'h01))
        |=> (bus_rdata == $past(pin_in[15:8])))
        else $error("data-in read not live pin level");

    chk_dout_back: assert property (@(posedge mclk) disable iff (!nrst)
        (io_sel && bus_wr && bus_addr == pcdr_pkg::OFF_DATA_OUT)
        ##1 (io_sel && bus_rd && !bus_wr
             && bus_addr == pcdr_pkg::OFF_DATA_OUT)
        |=> (bus_rdata == $past(bus_wdata, 2)))
        else $error("data-out readback differs from write");

    chk_mask_block: assert property (@(posedge mclk) disable iff (!nrst)
        (io_sel && bus_wr && bus_addr == pcdr_pkg::OFF_OCELL && mask_q[0][0])
        |=> (cell_state[0] == $past(cell_next[0])))
        else $error("masked output cell loaded from bus");

    chk_unmapped: assert property (@(posedge mclk) disable iff (!nrst)
        (io_sel && bus_rd && bus_addr == (pcdr_pkg::OFF_MODE + 8'h03))
        |=> (bus_rdata == 8'h00))
        else $error("absent register read nonzero");

    chk_enout_rd: assert property (@(posedge mclk) disable iff (!nrst)
        (io_sel && bus_rd && bus_addr == (pcdr_pkg::OFF_ENOUT + 8'h02))
        |=> (bus_rdata == $past(en_q[2])))
        else $error("enable-out read wrong");
endmodule

// [core/pcdr_pkg.sv]
// Shared constants for the port configuration and data register block
package pcdr_pkg;
    // Geometry
    localparam int NPORT = 4;
    localparam int NCELLPORT = 3;
    localparam int PW = 8;

    // Register base offsets; the port index is added in the low bits
    localparam logic [7:0] OFF_DATA_IN = 8'h00;
    localparam logic [7:0] OFF_DATA_OUT = 8'h04;
    localparam logic [7:0] OFF_MODE = 8'h08;
    localparam logic [7:0] OFF_DIR = 8'h0c;
    localparam logic [7:0] OFF_DRIVE = 8'h10;
    localparam logic [7:0] OFF_OCELL = 8'h14;
    localparam logic [7:0] OFF_MASK = 8'h18;
    localparam logic [7:0] OFF_ICELL = 8'h1c;
    localparam logic [7:0] OFF_ENOUT = 8'h20;

    // Address fields
    localparam int PORT_LSB = 0;
    localparam int PORT_W = 2;
    localparam int TYPE_LSB = 2;
    localparam int TYPE_W = 6;

    // Reset value of every configuration and data register
    localparam logic [7:0] RST_VAL = 8'h00;

    // Pin capabilities per port
    localparam logic [7:0] PIN_MASK_FULL = 8'hff;
    localparam logic [7:0] PIN_MASK_D = 8'h07;
    localparam logic [7:0] OD_MASK_AB = 8'hf0;
    localparam logic [7:0] SLEW_MASK_AB = 8'h0f;
    localparam logic [7:0] OD_MASK_C = 8'hff;
    localparam logic [7:0] SLEW_MASK_C = 8'h00;
    localparam logic [7:0] OD_MASK_D = 8'h00;
    localparam logic [7:0] SLEW_MASK_D = 8'h07;

    // Port indices
    localparam logic [1:0] PORT_A = 2'h0;
    localparam logic [1:0] PORT_B = 2'h1;
    localparam logic [1:0] PORT_C = 2'h2;
    localparam logic [1:0] PORT_D = 2'h3;

    // Whether a register type exists on a given port
    function automatic logic pcdr_exists(input logic [5:0] typ,
                                         input logic [1:0] port);
        logic ok;
        ok = 1'b0;
        if (typ == OFF_DATA_IN[7:2] || typ == OFF_DATA_OUT[7:2] ||
            typ == OFF_DIR[7:2] || typ == OFF_DRIVE[7:2]) begin
            ok = 1'b1;
        end else if (typ == OFF_MODE[7:2]) begin
            ok = (port == PORT_A) || (port == PORT_B);
        end else if (typ == OFF_OCELL[7:2] || typ == OFF_MASK[7:2] ||
                     typ == OFF_ICELL[7:2] || typ == OFF_ENOUT[7:2]) begin
            ok = (port != PORT_D);
        end
        return ok;
    endfunction
endpackage

// [core/pcdr_port.sv]
// One port: mode, direction, drive and data-out registers plus pin drivers
`timescale 1ns/1ps
module pcdr_port #(
    parameter logic [7:0] PIN_MASK = 8'hff,
    parameter logic [7:0] OD_MASK = 8'h00,
    parameter logic [7:0] SLEW_MASK = 8'h00,
    parameter bit HAS_MODE = 1'b1,
    parameter bit HAS_OEPT = 1'b1
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic wr_mode,
    input wire logic wr_dir,
    input wire logic wr_drive,
    input wire logic wr_dout,
    input wire logic [7:0] wdata,
    input wire logic [7:0] pld_oe,
    input wire logic [7:0] addr_val,
    output logic [7:0] mode,
    output logic [7:0] dir,
    output logic [7:0] drive,
    output logic [7:0] dout,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe,
    output logic [7:0] pin_fast,
    output logic [7:0] en_state
);
    logic [7:0] next_mode;
    logic [7:0] next_dir;
    logic [7:0] next_drive;
    logic [7:0] next_dout;
    logic [7:0] next_pin_out;
    logic [7:0] next_pin_oe;
    logic [7:0] next_pin_fast;
    logic [7:0] next_en;
    logic [7:0] drv_en;
    logic [7:0] val;
    logic [7:0] od;

    // Register writes and pin drive; unimplemented bits never store
    always_comb begin
        next_mode = mode;
        next_dir = dir;
        next_drive = drive;
        next_dout = dout;
        if (wr_mode && HAS_MODE) begin
            next_mode = wdata & PIN_MASK;
        end
        if (wr_dir) begin
            next_dir = wdata & PIN_MASK;
        end
        if (wr_drive) begin
            next_drive = wdata & PIN_MASK & (OD_MASK | SLEW_MASK);
        end
        if (wr_dout) begin
            next_dout = wdata & PIN_MASK;
        end
        // Driver on when direction bit or logic-array enable is set
        drv_en = (dir | (HAS_OEPT ? pld_oe : 8'h00)) & PIN_MASK;
        // Address output replaces data-out where mode bit is set
        val = (HAS_MODE ? (mode & addr_val) : 8'h00) |
              (~(HAS_MODE ? mode : 8'h00) & dout);
        od = drive & OD_MASK;
        // Open drain pulls low only, a one releases the pin
        next_pin_oe = drv_en & ~(od & val);
        next_pin_out = val & ~od & PIN_MASK;
        next_pin_fast = drive & SLEW_MASK;
        next_en = drv_en;
    end

    // All state clears at power-up
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            mode <= pcdr_pkg::RST_VAL;
            dir <= pcdr_pkg::RST_VAL;
            drive <= pcdr_pkg::RST_VAL;
            dout <= pcdr_pkg::RST_VAL;
            pin_out <= pcdr_pkg::RST_VAL;
            pin_oe <= pcdr_pkg::RST_VAL;
            pin_fast <= pcdr_pkg::RST_VAL;
            en_state <= pcdr_pkg::RST_VAL;
        end else begin
            mode <= next_mode;
            dir <= next_dir;
            drive <= next_drive;
            dout <= next_dout;
            pin_out <= next_pin_out;
            pin_oe <= next_pin_oe;
            pin_fast <= next_pin_fast;
            en_state <= next_en;
        end
    end
endmodule

// [core/pcdr_cells.sv]
// Output logic cell flip-flops of one port with their load mask
`timescale 1ns/1ps
module pcdr_cells #(
    parameter int N = 8
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic wr_cell,
    input wire logic wr_mask,
    input wire logic [N-1:0] wdata,
    input wire logic [N-1:0] cell_next,
    output logic [N-1:0] state,
    output logic [N-1:0] mask
);
    logic [N-1:0] next_state;
    logic [N-1:0] next_mask;

    // Masked cells keep following the array during a bus load
    always_comb begin
        next_mask = wr_mask ? wdata : mask;
        next_state = cell_next;
        if (wr_cell) begin
            next_state = (wdata & ~mask) | (cell_next & mask);
        end
    end

    // Cells and mask clear at power-up
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state <= N'(pcdr_pkg::RST_VAL);
            mask <= N'(pcdr_pkg::RST_VAL);
        end else begin
            state <= next_state;
            mask <= next_mask;
        end
    end
endmodule

// [tb/pcdr_pin_model.sv]
// Pin-side model: resolves each pad from the block's drivers and the board
`timescale 1ns/1ps
module pcdr_pin_model (
    input wire logic [31:0] pin_out,
    input wire logic [31:0] pin_oe,
    input wire logic [31:0] ext_lvl,
    output logic [31:0] pin_in
);
    // Released pads show the board level, reshuffled by the bench so a
    // stale driven value can never pass for the real pad level
    always_comb begin
        for (int i = 0; i < 32; i++) begin
            pin_in[i] = pin_oe[i] ? pin_out[i] : ext_lvl[i];
        end
    end
endmodule

// [tb/tb_top.sv]
// Self-checking bench for the port configuration and data register block
`timescale 1ns/1ps
module tb_top;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic io_sel = 1'b0;
    logic [7:0] bus_addr = 8'h00;
    logic [7:0] bus_wdata = 8'h00;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic [31:0] pin_in;
    logic [23:0] pld_oe = 24'h000000;
    logic [15:0] latched_addr = 16'h0000;
    logic [23:0] in_cell = 24'h000000;
    logic [23:0] cell_next = 24'h000000;
    logic [31:0] ext_lvl = 32'h00000000;
    logic [7:0] bus_rdata;
    logic [31:0] pin_out;
    logic [31:0] pin_oe;
    logic [31:0] pin_fast;
    logic [23:0] cell_state;
    logic [7:0] mdl [0:8][0:3];
    logic [7:0] exp_q [$];
    logic rd_pend = 1'b0;
    logic ovr = 1'b0;
    logic [7:0] ovr_val = 8'h00;
    integer seed = 67046;
    int miscompares = 0;
    int compares = 0;

    // 25 MHz clock
    always #20 mclk = ~mclk;

    pcdr_top dut (.mclk(mclk), .nrst(nrst), .io_sel(io_sel),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
        .bus_rd(bus_rd), .pin_in(pin_in), .pld_oe(pld_oe),
        .latched_addr(latched_addr), .in_cell(in_cell),
        .cell_next(cell_next), .bus_rdata(bus_rdata), .pin_out(pin_out),
        .pin_oe(pin_oe), .pin_fast(pin_fast), .cell_state(cell_state));

    pcdr_pin_model pads (.pin_out(pin_out), .pin_oe(pin_oe),
        .ext_lvl(ext_lvl), .pin_in(pin_in));

    function automatic logic [7:0] rnd8();
        logic [31:0] r;
        r = $random(seed);
        return r[7:0];
    endfunction

    // Bits a write can really change; absent registers keep nothing
    function automatic logic [7:0] wmask(input int t, input int p);
        case (t)
            1, 3, 4: return (p == 3) ? pcdr_pkg::PIN_MASK_D : 8'hff;
            2: return (p < 2) ? 8'hff : 8'h00;
            6: return (p < 3) ? 8'hff : 8'h00;
            default: return 8'h00;
        endcase
    endfunction

    function automatic logic [7:0] en_exp(input int p);
        if (p < 3)
            return mdl[3][p] | pld_oe[8*p +: 8];
        return mdl[3][p];
    endfunction

    // Expected {oe, out, fast} of one pad
    function automatic logic [2:0] pin_exp(input int p, input int i);
        logic [7:0] en;
        logic [7:0] odm;
        logic [7:0] slm;
        logic val;
        logic od;
        en = en_exp(p);
        odm = (p < 2) ? pcdr_pkg::OD_MASK_AB :
              (p == 2) ? pcdr_pkg::OD_MASK_C : pcdr_pkg::OD_MASK_D;
        slm = (p < 2) ? pcdr_pkg::SLEW_MASK_AB :
              (p == 2) ? pcdr_pkg::SLEW_MASK_C : pcdr_pkg::SLEW_MASK_D;
        val = (p < 2 && mdl[2][p][i]) ? latched_addr[8*p+i] : mdl[1][p][i];
        od = mdl[4][p][i] & odm[i];
        return {od ? en[i] & ~val : en[i], val & ~od, mdl[4][p][i] & slm[i]};
    endfunction

    // Expected read data; offsets follow the package's stride of four
    function automatic logic [7:0] exp_rd(input logic [7:0] a);
        int t;
        int p;
        logic [7:0] lv;
        logic [2:0] e;
        t = a[7:2];
        p = a[1:0];
        if (a >= 8'h24)
            return 8'h00;
        for (int i = 0; i < 8; i++) begin
            e = pin_exp(p, i);
            lv[i] = e[2] ? e[1] : ext_lvl[8*p+i];
        end
        case (t)
            0: return lv & wmask(1, p);
            5: return (p < 3) ? cell_next[8*p +: 8] : 8'h00;
            7: return (p < 3) ? in_cell[8*p +: 8] : 8'h00;
            8: return (p < 3) ? en_exp(p) : 8'h00;
            default: return mdl[t][p];
        endcase
    endfunction

    task automatic chk_rd(input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED t=%0t read exp=%h got=%h", $time, e, g);
        end
    endtask

    task automatic chk_pin(input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED t=%0t pins exp=%h got=%h", $time, e, g);
        end
    endtask

    // One bus cycle per call; the next call or an idle call ends it
    task automatic bus(input logic w, input logic r, input logic [7:0] a,
                       input logic [7:0] d);
        @(posedge mclk);
        io_sel <= w | r;
        bus_wr <= w;
        bus_rd <= r;
        bus_addr <= a;
        bus_wdata <= d;
        if (w && a < 8'h24)
            mdl[a[7:2]][a[1:0]] = d & wmask(a[7:2], a[1:0]);
        if (r)
            exp_q.push_back(ovr ? ovr_val : exp_rd(a));
    endtask

    task automatic reset_dut();
        nrst <= 1'b0;
        foreach (mdl[t, p])
            mdl[t][p] = 8'h00;
        repeat (6) @(posedge mclk);
        nrst <= 1'b1;
    endtask

    // Whole window plus unmapped offsets, back to back
    task automatic read_all();
        for (int a = 0; a < 8'h28; a++)
            bus(1'b0, 1'b1, 8'(a), 8'h00);
        bus(1'b0, 1'b1, 8'hff, 8'h00);
        bus(1'b0, 1'b0, 8'h00, 8'h00);
    endtask

    // Masked cells keep following the array during a bus load
    task automatic ocell_test(input int p);
        logic [7:0] d;
        logic [7:0] m;
        d = rnd8();
        m = mdl[6][p];
        ovr = 1'b1;
        ovr_val = (p < 3) ? (d & ~m) | (cell_next[8*p +: 8] & m) : 8'h00;
        bus(1'b1, 1'b0, pcdr_pkg::OFF_OCELL + 8'(p), d);
        bus(1'b0, 1'b1, pcdr_pkg::OFF_OCELL + 8'(p), 8'h00);
        ovr = 1'b0;
    endtask

    task automatic check_pins();
        logic [31:0] eo;
        logic [31:0] ev;
        logic [31:0] ef;
        logic [2:0] x;
        // Look between edges so the pad flops have settled
        @(negedge mclk);
        for (int p = 0; p < 4; p++) begin
            for (int i = 0; i < 8; i++) begin
                x = pin_exp(p, i);
                eo[8*p+i] = x[2];
                ev[8*p+i] = x[1];
                ef[8*p+i] = x[0];
            end
        end
        chk_pin(eo, pin_oe);
        chk_pin(ev, pin_out);
        chk_pin(ef, pin_fast);
    endtask

    task automatic summarize();
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Read results land one cycle after the read is taken
    always @(posedge mclk) begin
        if (rd_pend && exp_q.size() > 0)
            chk_rd(exp_q.pop_front(), bus_rdata);
        rd_pend <= io_sel & bus_rd;
    end

    // Sparse output-enable terms so the direction bits still matter
    task automatic scramble();
        @(posedge mclk);
        ext_lvl <= $random(seed);
        pld_oe <= 24'($random(seed) & $random(seed));
        latched_addr <= 16'($random(seed));
        in_cell <= 24'($random(seed));
        cell_next <= 24'($random(seed));
    endtask

    initial begin
        reset_dut();
        read_all();
        check_pins();
        repeat (12) begin
            scramble();
            for (int a = 0; a < 8'h28; a++)
                if (a[7:2] != 5)
                    bus(1'b1, 1'b0, 8'(a), rnd8());
            for (int p = 0; p < 4; p++)
                ocell_test(p);
            // Back-to-back data-out write and read of port A
            bus(1'b1, 1'b0, pcdr_pkg::OFF_DATA_OUT, rnd8());
            bus(1'b0, 1'b1, pcdr_pkg::OFF_DATA_OUT, 8'h00);
            repeat (3) bus(1'b0, 1'b0, 8'h00, 8'h00);
            check_pins();
            read_all();
        end
        // Second reset in mid-run clears everything again
        reset_dut();
        read_all();
        check_pins();
        repeat (4) @(posedge mclk);
        summarize();
    end

    // Run needs about 1200 cycles; give it 5000
    initial begin
        #200000;
        miscompares++;
        summarize();
    end
endmodule
